// *** mdc_defs.svh ***
// Register offsets, field positions and constants of the arithmetic unit
`ifndef MDC_DEFS_SVH
`define MDC_DEFS_SVH
`define MDC_A_MUL_A    8'h00
`define MDC_A_MUL_B    8'h04
`define MDC_A_MUL_LO   8'h08
`define MDC_A_MUL_HI   8'h0c
`define MDC_A_DVD      8'h10
`define MDC_A_DVS      8'h14
`define MDC_A_QUOT     8'h18
`define MDC_A_REM      8'h1c
`define MDC_A_DSTAT    8'h20
`define MDC_A_CRC_DATA 8'h24
`define MDC_A_CRC_SEED 8'h28
`define MDC_A_CRC_CTRL 8'h2c
`define MDC_A_CRC_SCR  8'h30
`define MDC_STAT_BUSY  0
`define MDC_STAT_DZ    1
`define MDC_CTRL_RIN   0
`define MDC_CTRL_ROUT  1
`define MDC_CRC_POLY   32'h04c11db7
`define MDC_CRC_SEED0  32'hffffffff
`define MDC_DIV_STEPS  5'h10
`define MDC_CNT_W32    3'h4
`define MDC_CNT_W16    3'h2
`define MDC_CNT_W8     3'h1
`define MDC_BE_W32     4'hf
`define MDC_BE_LO16    4'h3
`define MDC_BE_HI16    4'hc
`endif

// *** mdc_pkg.sv ***
// Types shared by the arithmetic unit
`default_nettype none
package mdc_pkg;
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } mdc_req_t;
    typedef struct packed {
        logic [31:0] data;
        logic [2:0]  cnt;
    } mdc_crc_word_t;
    typedef enum logic [0:0] {
        DIV_IDLE = 1'b0,
        DIV_RUN  = 1'b1
    } mdc_div_st_t;
endpackage
`default_nettype wire

// *** mdc_unit.sv ***
// Multiplier, signed divider and CRC-32 engine behind an Avalon-MM slave
// Behaviour
// - Multiplier gives full 32x32 product combinationally from operand registers.
// - Divider works on signed two's complement operands and results.
// - Dividend is 32 bits wide, divisor 16 bits wide.
// - Quotient 32 bits; 16-bit remainder sign-extended to 32 bits.
// - Starting a division with zero divisor sets a readable flag.
// - Each division takes 16 clock cycles until results are valid.
// - Writing the divisor starts a division; load dividend first.
// - Reading quotient or remainder while busy waits until done.
// - CRC-32 uses generator polynomial 0x4C11DB7.
// - CRC accepts 8, 16 or 32 bit input writes.
// - Software may load a starting value into the checksum.
// - One data register: writes feed data, reads give checksum.
// - Written input word is buffered so stalls spare running work.
// - Each input word is processed within 4 clock cycles.
// - An 8-bit scratch register is free for software.
// - Input and output bit order reversal are selectable.
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`default_nettype none
`include "mdc_defs.svh"

module mdc_unit
    import mdc_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest
);

    // ****************************************
    // Helpers
    // ****************************************
    // One restoring step: {quotient bit, new partial remainder}
    function automatic logic [17:0] div_step(input logic [16:0] rem, input logic b,
                                             input logic [16:0] d);
        logic [16:0] sh;
        sh = {rem[15:0], b};
        if (sh >= d) begin
            div_step = {1'b1, 17'(sh - d)};
        end else begin
            div_step = {1'b0, sh};
        end
    endfunction

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
        logic fb;
        crc_byte = c;
        for (int i = 7; i >= 0; i--) begin
            fb = crc_byte[31] ^ b[i];
            crc_byte = {crc_byte[30:0], 1'b0} ^ (fb ? `MDC_CRC_POLY : 32'h0);
        end
    endfunction

    function automatic logic [31:0] bit_rev(input logic [31:0] v, input logic per_byte);
        bit_rev = v;
        for (int i = 0; i < 32; i++) begin
            bit_rev[i] = per_byte ? v[(i & ~7) + 7 - (i & 7)] : v[31 - i];
        end
    endfunction

    // ****************************************
    // Bus decode
    // ****************************************
    mdc_req_t req;
    assign req = {avs_read, avs_write, avs_address, avs_byteenable, avs_writedata};

    wire hit_mula = req.addr == `MDC_A_MUL_A;
    wire hit_mulb = req.addr == `MDC_A_MUL_B;
    wire hit_dvd  = req.addr == `MDC_A_DVD;
    wire hit_dvs  = req.addr == `MDC_A_DVS;
    wire hit_quot = req.addr == `MDC_A_QUOT;
    wire hit_rem  = req.addr == `MDC_A_REM;
    wire hit_crc  = req.addr == `MDC_A_CRC_DATA;
    wire hit_seed = req.addr == `MDC_A_CRC_SEED;
    wire hit_ctrl = req.addr == `MDC_A_CRC_CTRL;
    wire hit_scr  = req.addr == `MDC_A_CRC_SCR;

    logic        rd_ack_r;
    logic [31:0] rdata_r;
    logic [31:0] mul_a_r, mul_b_r, dvd_r;
    logic [15:0] dvs_r;
    logic        dz_r;
    mdc_div_st_t st_r;
    logic [4:0]  cnt_r;
    logic [16:0] rem_r, dmag_r;
    logic [31:0] qsh_r, quot_r, remd_r;
    logic        qneg_r, rneg_r;
    logic [31:0] crc_r, seed_r;
    logic [1:0]  ctrl_r;
    logic [7:0]  scr_r;
    mdc_crc_word_t buf_r, eng_r;
    logic        buf_full_r;

    wire div_busy = st_r == DIV_RUN;
    // Checksum reads and seed loads wait for an idle engine,
    // so software never sees a half-folded word
    wire crc_idle = eng_r.cnt == 3'h0 && !buf_full_r;
    wire eng_free = eng_r.cnt <= 3'h1;

    wire stall_div = req.rd && (hit_quot || hit_rem) && div_busy;
    wire stall_crc = (req.wr && hit_crc && buf_full_r)
                   || (((req.rd && hit_crc) || (req.wr && hit_seed)) && !crc_idle);
    wire stall     = stall_div || stall_crc;
    // Ack flop blocks a second capture of the same read
    wire rd_go     = req.rd && !stall && !rd_ack_r;
    wire wr_go     = req.wr && !stall;

    // Read answers one cycle after acceptance so read data comes from a flop
    assign avs_waitrequest = req.rd ? !rd_ack_r : stall;
    assign avs_readdata    = rdata_r;

    // ****************************************
    // Multiplier
    // ****************************************
    // Combinational product
    // Long combinational path, traded for zero latency
    wire [63:0] product = 64'(mul_a_r) * 64'(mul_b_r);

    // ****************************************
    // Divider
    // ****************************************
    // Divisor write starts
    wire        div_start = wr_go && hit_dvs;
    wire [15:0] dvs_in    = req.wdata[15:0];
    wire [16:0] dvs_mag   = dvs_in[15] ? 17'(17'h0 - {1'b1, dvs_in}) : {1'b0, dvs_in};
    wire [31:0] dvd_mag   = dvd_r[31] ? 32'(32'h0 - dvd_r) : dvd_r;

    // Two quotient bits per cycle, 16 cycles
    wire [17:0] st1     = div_step(rem_r, qsh_r[31], dmag_r);
    wire [17:0] st2     = div_step(st1[16:0], qsh_r[30], dmag_r);
    wire [31:0] qsh_nxt = {qsh_r[29:0], st1[17], st2[17]};
    wire [31:0] quot_nxt = qneg_r ? 32'(32'h0 - qsh_nxt) : qsh_nxt;
    wire [15:0] rem16    = rneg_r ? 16'(16'h0 - st2[15:0]) : st2[15:0];
    wire [31:0] remd_nxt = {{16{rem16[15]}}, rem16};

    // Zero divisor still runs all steps, so busy time never
    // depends on the operands; its results carry no meaning

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_r   <= DIV_IDLE;
            cnt_r  <= 5'h0;
            rem_r  <= 17'h0;
            dmag_r <= 17'h0;
            qsh_r  <= 32'h0;
            qneg_r <= 1'b0;
            rneg_r <= 1'b0;
            quot_r <= 32'h0;
            remd_r <= 32'h0;
            dz_r   <= 1'b0;
        end else if (div_start) begin
            st_r   <= DIV_RUN;
            cnt_r  <= `MDC_DIV_STEPS;
            rem_r  <= 17'h0;
            dmag_r <= dvs_mag;
            qsh_r  <= dvd_mag;
            qneg_r <= dvd_r[31] ^ dvs_in[15];
            rneg_r <= dvd_r[31];
            dz_r   <= dvs_in == 16'h0;
        end else if (div_busy) begin
            rem_r <= st2[16:0];
            qsh_r <= qsh_nxt;
            cnt_r <= cnt_r - 5'h1;
            if (cnt_r == 5'h1) begin
                st_r   <= DIV_IDLE;
                quot_r <= quot_nxt;
                remd_r <= remd_nxt;
            end
        end
    end

    // ****************************************
    // CRC engine
    // ****************************************
    // Per-byte input reversal
    wire [31:0] wd_in = bit_rev(req.wdata, 1'b1);
    wire [31:0] wd    = ctrl_r[`MDC_CTRL_RIN] ? wd_in : req.wdata;
    wire [7:0]  lane8 = req.be[3] ? wd[31:24] : req.be[2] ? wd[23:16]
                      : req.be[1] ? wd[15:8]  : wd[7:0];
    wire [15:0] lane16 = req.be[2] ? wd[31:16] : wd[15:0];
    // 8, 16 or 32 bit input
    mdc_crc_word_t in_w;
    assign in_w = (req.be == `MDC_BE_W32) ? {wd, `MDC_CNT_W32}
                : (req.be == `MDC_BE_LO16 || req.be == `MDC_BE_HI16)
                  ? {lane16, 16'h0, `MDC_CNT_W16}
                  : {lane8, 24'h0, `MDC_CNT_W8};
    wire crc_wr = wr_go && hit_crc;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            buf_r      <= '0;
            buf_full_r <= 1'b0;
            eng_r      <= '0;
            crc_r      <= `MDC_CRC_SEED0;
        end else begin
            if (eng_r.cnt != 3'h0) begin
                crc_r <= crc_byte(crc_r, eng_r.data[31:24]);
            end
            // Parked word goes first to keep input order
            if (eng_free && buf_full_r) begin
                eng_r      <= buf_r;
                buf_full_r <= 1'b0;
            end else if (eng_free && crc_wr) begin
                eng_r <= in_w;
            end else if (eng_r.cnt != 3'h0) begin
                eng_r <= {eng_r.data << 8, 3'(eng_r.cnt - 3'h1)};
            end
            if (crc_wr && !eng_free) begin
                buf_r      <= in_w;
                buf_full_r <= 1'b1;
            end
            if (wr_go && hit_seed) begin
                crc_r <= req.wdata;
            end
        end
    end

    // ****************************************
    // Registers and read path
    // ****************************************
    // Data reads give checksum
    wire [31:0] crc_out = ctrl_r[`MDC_CTRL_ROUT] ? bit_rev(crc_r, 1'b0) : crc_r;
    // Unmapped offsets read as zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        unique case (req.addr)
            `MDC_A_MUL_A:    rd_mux = mul_a_r;
            `MDC_A_MUL_B:    rd_mux = mul_b_r;
            `MDC_A_MUL_LO:   rd_mux = product[31:0];
            `MDC_A_MUL_HI:   rd_mux = product[63:32];
            `MDC_A_DVD:      rd_mux = dvd_r;
            `MDC_A_DVS:      rd_mux = {16'h0, dvs_r};
            `MDC_A_QUOT:     rd_mux = quot_r;
            `MDC_A_REM:      rd_mux = remd_r;
            `MDC_A_DSTAT:    rd_mux = {30'h0, dz_r, div_busy};
            `MDC_A_CRC_DATA: rd_mux = crc_out;
            `MDC_A_CRC_SEED: rd_mux = seed_r;
            `MDC_A_CRC_CTRL: rd_mux = {30'h0, ctrl_r};
            `MDC_A_CRC_SCR:  rd_mux = {24'h0, scr_r};
            default:         rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rd_ack_r <= 1'b0;
            rdata_r  <= 32'h0;
        end else begin
            rd_ack_r <= rd_go;
            if (rd_go) begin
                rdata_r <= rd_mux;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mul_a_r <= 32'h0;
            mul_b_r <= 32'h0;
            dvd_r   <= 32'h0;
            dvs_r   <= 16'h0;
            seed_r  <= `MDC_CRC_SEED0;
            ctrl_r  <= 2'h0;
            scr_r   <= 8'h0;
        end else if (wr_go) begin
            if (hit_mula) mul_a_r <= req.wdata;
            if (hit_mulb) mul_b_r <= req.wdata;
            if (hit_dvd)  dvd_r   <= req.wdata;
            if (hit_dvs)  dvs_r   <= dvs_in;
            if (hit_seed) seed_r  <= req.wdata;
            if (hit_ctrl) ctrl_r  <= req.wdata[1:0];
            if (hit_scr)  scr_r   <= req.wdata[7:0];
        end
    end

endmodule // mdc_unit
`default_nettype wire

// *** mdc_unit_sva.sv ***
// Checker for the arithmetic unit bus behaviour
`default_nettype none
`include "mdc_defs.svh"
module mdc_unit_sva
    import mdc_pkg::*;
(
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rstn,
    // Avalon-MM slave
    input wire logic [7:0]  avs_address,
    input wire logic [3:0]  avs_byteenable,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic [31:0] ma_r, mb_r, dvd_r;
    logic [15:0] dvs_r;
    logic [7:0]  scr_r;
    logic [4:0]  cnt_r;
    logic        dz_r;
    wire         wr_ok = avs_write && !avs_waitrequest;
    wire         rd_ok = avs_read && !avs_waitrequest;
    wire         wr_dvs = wr_ok && avs_address == `MDC_A_DVS;
    wire  [63:0] prod = {32'h0, ma_r} * {32'h0, mb_r};
    wire  [31:0] dvs_x = {{16{dvs_r[15]}}, dvs_r};
    wire  [31:0] q_exp = $signed(dvd_r) / $signed(dvs_x);
    wire  [31:0] r_exp = $signed(dvd_r) % $signed(dvs_x);
    // Overflow and zero divisor leave results undefined
    wire         ok_div = dvs_r != 16'h0 && !(dvd_r == 32'h80000000 && dvs_r == 16'hffff);
    wire         is_qr = avs_address == `MDC_A_QUOT || avs_address == `MDC_A_REM;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            {ma_r, mb_r, dvd_r, dvs_r, scr_r, cnt_r, dz_r} <= '0;
        end else begin
            if (wr_ok && avs_address == `MDC_A_MUL_A) ma_r <= avs_writedata;
            if (wr_ok && avs_address == `MDC_A_MUL_B) mb_r <= avs_writedata;
            if (wr_ok && avs_address == `MDC_A_DVD) dvd_r <= avs_writedata;
            if (wr_ok && avs_address == `MDC_A_CRC_SCR) scr_r <= avs_writedata[7:0];
            if (wr_dvs) dvs_r <= avs_writedata[15:0];
            if (wr_dvs) dz_r <= avs_writedata[15:0] == 16'h0;
            cnt_r <= wr_dvs ? 5'h10 : (cnt_r != 5'h0) ? cnt_r - 5'h1 : cnt_r;
        end
    end
    a_mul_product: assert property (
        rd_ok && (avs_address == `MDC_A_MUL_LO || avs_address == `MDC_A_MUL_HI)
        |-> avs_readdata == (avs_address[2] ? prod[63:32] : prod[31:0]))
        else $error("multiplier product mismatch");
    a_quot_value: assert property (
        rd_ok && avs_address == `MDC_A_QUOT && ok_div |-> avs_readdata == q_exp)
        else $error("quotient mismatch");
    a_rem_value: assert property (
        rd_ok && avs_address == `MDC_A_REM && ok_div |-> avs_readdata == r_exp)
        else $error("remainder mismatch");
    a_dz_flag: assert property (
        rd_ok && avs_address == `MDC_A_DSTAT |-> avs_readdata[1] == dz_r)
        else $error("zero divide flag mismatch");
    a_div_stall: assert property (
        avs_read && is_qr && cnt_r != 5'h0 |-> avs_waitrequest)
        else $error("result read not stalled during division");
    a_div_bound: assert property (
        $rose(avs_read) && is_qr |-> ##[1:17] !avs_waitrequest)
        else $error("division result late");
    a_crc_bound: assert property (
        $rose(avs_read) && avs_address == `MDC_A_CRC_DATA |-> ##[1:9] !avs_waitrequest)
        else $error("checksum read late");
    a_scr_hold: assert property (
        rd_ok && avs_address == `MDC_A_CRC_SCR |-> avs_readdata[7:0] == scr_r)
        else $error("scratch readback mismatch");
endmodule // mdc_unit_sva
bind mdc_unit mdc_unit_sva mdc_unit_sva_i (.mclk(mclk), .rstn(rstn),
    .avs_address(avs_address), .avs_byteenable(avs_byteenable), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
`default_nettype wire

// *** mdc_cpu_model.sv ***
// Processor-side bus master model for the arithmetic unit
`default_nettype none
module mdc_cpu_model (
    // Clock
    input  wire logic        mclk,
    // Avalon-MM master
    output var  logic [7:0]  avs_address,
    output var  logic [3:0]  avs_byteenable,
    output var  logic        avs_read,
    output var  logic        avs_write,
    output var  logic [31:0] avs_writedata,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {avs_address, avs_byteenable, avs_read, avs_write, avs_writedata} = '0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] d, output logic [31:0] q, output int n);
        n = 0;
        avs_write      <= w;
        avs_read       <= !w;
        avs_address    <= a;
        avs_byteenable <= be;
        avs_writedata  <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write     <= 1'b0;
        avs_read      <= 1'b0;
        // Stale data must not look valid
        avs_writedata <= ~d;
        @(posedge mclk);
    endtask
endmodule // mdc_cpu_model
`default_nettype wire

// *** test_mdc_unit.sv ***
// Self-checking bench for the arithmetic unit
`default_nettype none
`include "mdc_defs.svh"
module test_mdc_unit;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, rstn, avs_read, avs_write, avs_waitrequest;
    logic [7:0]  avs_address;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, q, a, b, s, c;
    logic [3:0]  bes [8] = '{4'hf, 4'h3, 4'hc, 4'h1, 4'h2, 4'h4, 4'h8, 4'h6};
    logic [1:0]  md;
    int          n, n_errors = 0, total_checks = 0, cyc = 0;
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    mdc_unit mdc_unit_i (.mclk(mclk), .rstn(rstn), .avs_address(avs_address),
        .avs_byteenable(avs_byteenable), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    mdc_cpu_model mdc_cpu_model_i (.mclk(mclk), .avs_address(avs_address),
        .avs_byteenable(avs_byteenable), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [3:0] be, input logic [31:0] d);
        mdc_cpu_model_i.xfer(1'b1, ad, be, d, q, n);
    endtask
    task automatic rd(input logic [7:0] ad);
        mdc_cpu_model_i.xfer(1'b0, ad, 4'hf, 32'h0, q, n);
    endtask
    function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] d,
                                         input logic rv);
        for (int i = 7; i >= 0; i--) begin
            c = (c << 1) ^ ((c[31] ^ (rv ? d[7-i] : d[i])) ? `MDC_CRC_POLY : 32'h0);
        end
        return c;
    endfunction
    // Narrow writes fold only their own lanes, high lane first
    function automatic logic [31:0] crcw(input logic [31:0] c, input logic [31:0] d,
                                         input logic [3:0] be, input logic rv);
        int hi, nb;
        hi = be[3] ? 3 : be[2] ? 2 : be[1] ? 1 : 0;
        nb = (be == 4'hf) ? 4 : (be == 4'h3 || be == 4'hc) ? 2 : 1;
        for (int j = 0; j < nb; j++) c = crc8(c, d[8*(hi-j) +: 8], rv);
        return c;
    endfunction
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            summarize();
        end
    end
    initial begin
        rstn = 1'b0;
        void'($urandom(32'h4f56892a));
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rd(`MDC_A_CRC_DATA);
        chk("crc_reset", `MDC_CRC_SEED0, q);
        for (int i = 0; i < 4; i++) begin
            a = i == 0 ? 32'hffffffff : $urandom;
            b = i == 0 ? 32'hffffffff : $urandom;
            wr(`MDC_A_MUL_A, 4'hf, a);
            wr(`MDC_A_MUL_B, 4'hf, b);
            rd(`MDC_A_MUL_LO);
            chk("mul_lo", 32'({32'h0, a} * {32'h0, b}), q);
            rd(`MDC_A_MUL_HI);
            chk("mul_hi", 32'(({32'h0, a} * {32'h0, b}) >> 32), q);
        end
        $display("test mul done");
        for (int i = 0; i < 7; i++) begin
            a = i < 4 ? (i[0] ? 32'hfffffff9 : 32'h7) : $urandom;
            b = i < 4 ? (i[1] ? 32'hfffe : 32'h2) : $urandom_range(32'hffff, 1);
            s = {{16{b[15]}}, b[15:0]};
            wr(`MDC_A_DVD, 4'hf, a);
            wr(`MDC_A_DVS, 4'hf, b);
            rd(`MDC_A_QUOT);
            // Read opens one edge after the start, then one wait state after the end
            chk("div_wait", 32'(`MDC_DIV_STEPS) + 32'd1, 32'(n));
            chk("quot", 32'($signed(a) / $signed(s)), q);
            rd(`MDC_A_REM);
            chk("rem", 32'($signed(a) % $signed(s)), q);
        end
        wr(`MDC_A_DVS, 4'hf, 32'h0);
        rd(`MDC_A_DSTAT);
        chk("dz_set", 32'h1, {31'h0, q[1]});
        rd(`MDC_A_QUOT);
        rd(`MDC_A_DSTAT);
        chk("dz_hold", 32'h2, q);
        wr(`MDC_A_DVS, 4'hf, 32'h3);
        rd(`MDC_A_REM);
        rd(`MDC_A_DSTAT);
        chk("dz_clear", 32'h0, q);
        $display("test div done");
        c = $urandom;
        wr(`MDC_A_CRC_SEED, 4'hf, c);
        rd(`MDC_A_CRC_SEED);
        chk("seed", c, q);
        for (int i = 0; i < 16; i++) begin
            md = i[3:2];
            if (i[1:0] == 2'h0) wr(`MDC_A_CRC_CTRL, 4'hf, {30'h0, md});
            a = i == 0 ? 32'h0 : $urandom;
            wr(`MDC_A_CRC_DATA, bes[i & 7], a);
            c = crcw(c, a, bes[i & 7], md[0]);
            if (i == 5) begin
                s = $urandom;
                wr(`MDC_A_CRC_SCR, 4'hf, s);
                rd(`MDC_A_CRC_SCR);
                chk("scratch", {24'h0, s[7:0]}, q);
            end
            if (i[0]) begin
                rd(`MDC_A_CRC_DATA);
                s = {<<{c}};
                chk("crc", md[1] ? s : c, q);
            end
        end
        $display("test crc done");
        wr(8'h3c, 4'hf, $urandom);
        rd(8'h3c);
        chk("unmapped", 32'h0, q);
        $display("test unmapped done");
        summarize();
    end
endmodule // test_mdc_unit
`default_nettype wire
